// ---- sbpr_params.svh ----
// register indices, field positions, reset values and timing figures of the base register bank
`ifndef SBPR_PARAMS_SVH
`define SBPR_PARAMS_SVH
// register indices; byte address is four times the index
`define SBPR_IDX_NODE 4'h0
`define SBPR_IDX_ROOTGAP 4'h1
`define SBPR_IDX_EXTPORT 4'h2
`define SBPR_IDX_SPDSTBY 4'h3
`define SBPR_IDX_LINKPWR 4'h4
`define SBPR_IDX_EVENT 4'h5
`define SBPR_IDX_LEGACY 4'h6
`define SBPR_IDX_PAGE 4'h7
// bit position 0 is the msb, so field bits are given as data bit numbers
`define SBPR_B_ROOT 1
`define SBPR_B_CPS 0
`define SBPR_B_HOLDOFF 7
`define SBPR_B_LONGRST 6
`define SBPR_B_STANDBY 4
`define SBPR_B_LINKCTL 7
`define SBPR_B_CONTEND 6
`define SBPR_B_WAKEEN 7
`define SBPR_B_SHORTRST 6
`define SBPR_B_CFGTO 5
`define SBPR_B_PWRDROP 4
`define SBPR_B_STATETO 3
`define SBPR_B_PORTEV 2
`define SBPR_B_ARBACC 1
`define SBPR_B_MULTISPD 0
// fixed field values and the gap count reset value
`define SBPR_GAP_RESET 6'h3f
`define SBPR_EXT_CODE 3'h7
`define SBPR_NUM_PORTS 4'h3
`define SBPR_LEGACY_SPD 3'h7
`define SBPR_DELAY_CODE 4'hf
`define SBPR_JITTER_CODE 3'h0
// bus reset lengths in ns and clock period in ns
`define SBPR_LONG_RESET_NS 166000
`define SBPR_SHORT_RESET_NS 1300
`define SBPR_CLK_NS 40
// axi responses
`define SBPR_RESP_OKAY 2'h0
`define SBPR_RESP_SLVERR 2'h2
`endif

// ---- sbpr_pkg.sv ----
// types of the base register bank
package sbpr_pkg;
  // bus reset generator state, one-hot
  typedef enum logic [2:0] {
    SBPR_RST_IDLE  = 3'h1,
    SBPR_RST_LONG  = 3'h2,
    SBPR_RST_SHORT = 3'h4
  } sbpr_rst_state_t;
endpackage

// ---- sbpr_page_mem.sv ----
// small byte memory holding the paged registers, registered read data
`timescale 1ns/1ps
`default_nettype none
module sbpr_page_mem #(
  parameter int ADDR_W = 6,
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write port
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  // read port
  input wire logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);
  // storage array, no reset
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // write
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ---- sbpr_top.sv ----
// base register bank of a three-port serial bus phy, reached over axi4-lite
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sbpr_params.svh"
module sbpr_top import sbpr_pkg::*; #(
  parameter int AW = 8,
  parameter int LONG_CYC = (`SBPR_LONG_RESET_NS + `SBPR_CLK_NS - 1) / `SBPR_CLK_NS,
  parameter int SHORT_CYC = (`SBPR_SHORT_RESET_NS + `SBPR_CLK_NS - 1) / `SBPR_CLK_NS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // events from the phy core
  input wire logic bus_reset_in,
  input wire logic self_id_done,
  input wire logic [5:0] self_id_node_number,
  input wire logic tree_id_root,
  input wire logic cfg_pkt_gap_load,
  input wire logic [5:0] cfg_pkt_gap_count,
  input wire logic cfg_pkt_holdoff_load,
  input wire logic cfg_pkt_holdoff,
  input wire logic traffic_busy,
  input wire logic resume_start,
  input wire logic config_timeout_event,
  input wire logic state_timeout_event,
  input wire logic standby_cmd,
  input wire logic leaf_node,
  // pins from outside the clock domain
  input wire logic cable_power_ok_pin,
  input wire logic link_power_status_in,
  input wire logic [2:0] pwr_class_strap,
  // outputs to the phy core
  output logic reg0_status_push,
  output logic [7:0] reg0_status_data,
  output logic node_number_valid,
  output logic bus_reset_drive,
  output logic bus_reset_is_short,
  output logic root_holdoff,
  output logic [5:0] gap_count,
  output logic standby_enter,
  output logic self_id_link_active,
  output logic self_id_contender,
  output logic [2:0] self_id_pwr_class,
  output logic [3:0] port_select
);
  localparam int CW = $clog2(((LONG_CYC > SHORT_CYC) ? LONG_CYC : SHORT_CYC) + 1); // longer one
  localparam logic [CW-1:0] LONG_LAST = CW'(LONG_CYC - 1);
  localparam logic [CW-1:0] SHORT_LAST = CW'(SHORT_CYC - 1);

  // register fields
  logic [5:0] node_number; // node number from self-id
  logic root_flag; // this node is root
  logic long_reset_request; // long reset pending
  logic standby_allow; // standby permitted
  logic link_active_ctl; // link active control
  logic contender; // contender bit
  logic [2:0] pwr_class; // power class
  logic port_event_wake_en; // wake enable
  logic short_reset_request; // short reset pending
  logic config_timeout_flag; // sticky timeout flag
  logic power_drop_flag; // sticky power drop flag
  logic state_timeout_flag; // sticky state timeout flag
  logic port_event_flag; // sticky port event flag
  logic arb_accel_en; // arbitration acceleration enable
  logic multispeed_en; // multispeed concatenation enable
  logic [7:0] legacy_reg; // max legacy speed, blink, bridge
  logic [2:0] page_select; // paged window choice
  logic strap_done; // strap captured
  logic gap_reset_pending; // a bus reset since last gap update

  // synchronisers and reset generator
  logic cps_s1, cps_s2, cps_s3; // cable power sync and edge stage
  logic lps_s1, lps_s2; // link power sync
  sbpr_rst_state_t rst_state;
  logic [CW-1:0] rst_cnt; // bus reset duration counter
  logic bus_reset_evt; // any bus reset begins this cycle
  logic own_start_long, own_start_short;

  // axi state
  logic aw_held, w_held; // channel payloads captured
  logic [AW-1:0] aw_addr;
  logic [7:0] w_byte; // low byte lane of the write
  logic w_lane; // low byte strobe
  logic rd_pend; // memory read in flight
  logic rd_err; // read address unmapped
  logic [3:0] rd_idx;
  logic rd_page_ok; // page holds real registers
  logic wr_fire; // write performed this cycle
  logic wr_err;
  logic [3:0] wr_idx;
  logic wr_base, wr_page_ok, wr_en;
  logic [7:0] mem_rdata;
  logic [7:0] base_rd; // composed base register value
  logic next_link_low_event;

  // pin synchronisers; second stage feeds the logic, cps_s3 only the cable power falling edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cps_s1 <= 1'b0;
      cps_s2 <= 1'b0;
      cps_s3 <= 1'b0;
      lps_s1 <= 1'b0;
      lps_s2 <= 1'b0;
    end else begin
      cps_s1 <= cable_power_ok_pin;
      cps_s2 <= cps_s1;
      cps_s3 <= cps_s2;
      lps_s1 <= link_power_status_in;
      lps_s2 <= lps_s1;
    end
  end

  // write decode
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_idx = aw_addr[5:2];
  assign wr_err = (aw_addr[AW-1:6] != '0) || (aw_addr[1:0] != 2'h0);
  assign wr_en = wr_fire && !wr_err && w_lane;
  assign wr_base = wr_en && !wr_idx[3];
  // pages 0, 1 and 7 hold storage, the rest are reserved
  assign wr_page_ok = (page_select <= 3'h1) || (page_select == 3'h7);

  // own reset starts: long first, only when no traffic and idle
  assign own_start_long = (rst_state == SBPR_RST_IDLE) && long_reset_request && !traffic_busy;
  assign own_start_short = (rst_state == SBPR_RST_IDLE) && !long_reset_request
                           && short_reset_request && !traffic_busy;
  assign bus_reset_evt = bus_reset_in || own_start_long || own_start_short;

  // bus reset generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_state <= SBPR_RST_IDLE;
      rst_cnt <= '0;
    end else begin
      case (rst_state)
        SBPR_RST_IDLE: begin
          rst_cnt <= '0;
          if (own_start_long) begin
            rst_state <= SBPR_RST_LONG;
          end else if (own_start_short) begin
            rst_state <= SBPR_RST_SHORT;
          end
        end
        SBPR_RST_LONG: begin
          // held for the full long duration
          if (rst_cnt == LONG_LAST) begin
            rst_state <= SBPR_RST_IDLE;
          end else begin
            rst_cnt <= rst_cnt + 1'b1;
          end
        end
        SBPR_RST_SHORT: begin
          if (rst_cnt == SHORT_LAST) begin
            rst_state <= SBPR_RST_IDLE;
          end else begin
            rst_cnt <= rst_cnt + 1'b1;
          end
        end
        default: begin
          rst_state <= SBPR_RST_IDLE;
        end
      endcase
    end
  end
  assign bus_reset_drive = (rst_state != SBPR_RST_IDLE);
  assign bus_reset_is_short = (rst_state == SBPR_RST_SHORT);

  // node identity and root; status push marks the node number valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      node_number <= '0;
      node_number_valid <= 1'b0;
      root_flag <= 1'b0;
      reg0_status_push <= 1'b0;
      reg0_status_data <= '0;
    end else begin
      reg0_status_push <= 1'b0;
      if (tree_id_root) begin
        root_flag <= 1'b1;
      end else if (bus_reset_evt) begin
        root_flag <= 1'b0;
      end
      if (self_id_done) begin
        node_number <= self_id_node_number;
        node_number_valid <= 1'b1;
        reg0_status_push <= 1'b1;
        reg0_status_data <= {self_id_node_number, root_flag, cps_s2};
      end else if (bus_reset_evt) begin
        node_number_valid <= 1'b0;
      end
    end
  end

  // register 1: holdoff, long reset request, gap count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      root_holdoff <= 1'b0;
      long_reset_request <= 1'b0;
      gap_count <= `SBPR_GAP_RESET;
      gap_reset_pending <= 1'b0;
    end else begin
      if (cfg_pkt_holdoff_load) begin
        root_holdoff <= cfg_pkt_holdoff;
      end else if (wr_base && wr_idx == `SBPR_IDX_ROOTGAP) begin
        root_holdoff <= w_byte[`SBPR_B_HOLDOFF];
      end
      if (bus_reset_evt) begin
        long_reset_request <= 1'b0;
      end else if (wr_base && wr_idx == `SBPR_IDX_ROOTGAP) begin
        long_reset_request <= w_byte[`SBPR_B_LONGRST];
      end
      if (cfg_pkt_gap_load) begin
        gap_count <= cfg_pkt_gap_count;
        gap_reset_pending <= 1'b0;
      end else if (wr_base && wr_idx == `SBPR_IDX_ROOTGAP) begin
        gap_count <= w_byte[5:0];
        gap_reset_pending <= 1'b0;
      end else if (bus_reset_evt) begin
        // second reset with no update in between restores the default
        if (gap_reset_pending) begin
          gap_count <= `SBPR_GAP_RESET;
        end
        gap_reset_pending <= 1'b1;
      end
    end
  end

  // registers 3, 4, 6, 7: plain writable fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_allow <= 1'b0;
      link_active_ctl <= 1'b1;
      contender <= 1'b0;
      pwr_class <= '0;
      strap_done <= 1'b0;
      legacy_reg <= '0;
      page_select <= '0;
      port_select <= '0;
    end else begin
      // strap caught on the first edge after release
      if (!strap_done) begin
        pwr_class <= pwr_class_strap;
        strap_done <= 1'b1;
      end else if (wr_base && wr_idx == `SBPR_IDX_LINKPWR) begin
        pwr_class <= w_byte[2:0];
      end
      if (wr_base && wr_idx == `SBPR_IDX_SPDSTBY) begin
        standby_allow <= w_byte[`SBPR_B_STANDBY];
      end
      if (wr_base && wr_idx == `SBPR_IDX_LINKPWR) begin
        link_active_ctl <= w_byte[`SBPR_B_LINKCTL];
        contender <= w_byte[`SBPR_B_CONTEND];
      end
      if (wr_base && wr_idx == `SBPR_IDX_LEGACY) begin
        legacy_reg <= {w_byte[7:2], 2'h0};
      end
      if (wr_base && wr_idx == `SBPR_IDX_PAGE) begin
        page_select <= w_byte[7:5];
        port_select <= w_byte[3:0];
      end
    end
  end

  // standby grant only for leaf nodes with standby allowed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_enter <= 1'b0;
    end else begin
      standby_enter <= standby_cmd && standby_allow && leaf_node;
    end
  end

  // self-id packet fields
  assign self_id_link_active = link_active_ctl && lps_s2;
  assign self_id_contender = contender;
  assign self_id_pwr_class = pwr_class;

  // register 5: event flags, hardware set wins over write-one-to-clear
  assign next_link_low_event = (config_timeout_event || state_timeout_event
                               || (cps_s3 && !cps_s2)) && !lps_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_event_wake_en <= 1'b0;
      short_reset_request <= 1'b0;
      config_timeout_flag <= 1'b0;
      power_drop_flag <= 1'b0;
      state_timeout_flag <= 1'b0;
      port_event_flag <= 1'b0;
      arb_accel_en <= 1'b0;
      multispeed_en <= 1'b0;
    end else begin
      if (wr_base && wr_idx == `SBPR_IDX_EVENT) begin
        port_event_wake_en <= w_byte[`SBPR_B_WAKEEN];
        arb_accel_en <= w_byte[`SBPR_B_ARBACC];
        multispeed_en <= w_byte[`SBPR_B_MULTISPD];
      end
      if (bus_reset_evt) begin
        short_reset_request <= 1'b0;
      end else if (wr_base && wr_idx == `SBPR_IDX_EVENT) begin
        short_reset_request <= w_byte[`SBPR_B_SHORTRST];
      end
      if (config_timeout_event) begin
        config_timeout_flag <= 1'b1;
      end else if (wr_base && wr_idx == `SBPR_IDX_EVENT && w_byte[`SBPR_B_CFGTO]) begin
        config_timeout_flag <= 1'b0;
      end
      if (cps_s3 && !cps_s2) begin
        power_drop_flag <= 1'b1;
      end else if (wr_base && wr_idx == `SBPR_IDX_EVENT && w_byte[`SBPR_B_PWRDROP]) begin
        power_drop_flag <= 1'b0;
      end
      if (state_timeout_event) begin
        state_timeout_flag <= 1'b1;
      end else if (wr_base && wr_idx == `SBPR_IDX_EVENT && w_byte[`SBPR_B_STATETO]) begin
        state_timeout_flag <= 1'b0;
      end
      if (port_event_wake_en && (resume_start || next_link_low_event)) begin
        port_event_flag <= 1'b1;
      end else if (wr_base && wr_idx == `SBPR_IDX_EVENT && w_byte[`SBPR_B_PORTEV]) begin
        port_event_flag <= 1'b0;
      end
    end
  end

  // paged register storage, indexed by page and low address
  sbpr_page_mem #(
    .ADDR_W(6),
    .DATA_W(8)
  ) u_page_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(wr_en && wr_idx[3] && wr_page_ok),
    .waddr({page_select, wr_idx[2:0]}),
    .wdata(w_byte),
    .raddr({page_select, araddr[4:2]}),
    .rdata(mem_rdata)
  );

  // write channels: address and data taken in any order
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= '0;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SBPR_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_err ? `SBPR_RESP_SLVERR : `SBPR_RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // base register read mux; fixed codes and zeros in reserved bits
  always_comb begin
    base_rd = 8'h00;
    case (rd_idx)
      `SBPR_IDX_NODE: base_rd = {node_number, root_flag, cps_s2};
      `SBPR_IDX_ROOTGAP: base_rd = {root_holdoff, long_reset_request, gap_count};
      `SBPR_IDX_EXTPORT: base_rd = {`SBPR_EXT_CODE, 1'b0, `SBPR_NUM_PORTS};
      `SBPR_IDX_SPDSTBY: base_rd = {`SBPR_LEGACY_SPD, standby_allow, `SBPR_DELAY_CODE};
      `SBPR_IDX_LINKPWR: base_rd = {link_active_ctl, contender, `SBPR_JITTER_CODE, pwr_class};
      `SBPR_IDX_EVENT: base_rd = {port_event_wake_en, short_reset_request, config_timeout_flag,
                                  power_drop_flag, state_timeout_flag, port_event_flag,
                                  arb_accel_en, multispeed_en};
      `SBPR_IDX_LEGACY: base_rd = legacy_reg;
      `SBPR_IDX_PAGE: base_rd = {page_select, 1'b0, port_select};
      default: base_rd = 8'h00;
    endcase
  end

  // read channel: one cycle for the memory, then the answer; no side effects
  assign arready = !rd_pend && !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend <= 1'b0;
      rd_err <= 1'b0;
      rd_idx <= '0;
      rd_page_ok <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `SBPR_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        rd_pend <= 1'b1;
        rd_idx <= araddr[5:2];
        rd_err <= (araddr[AW-1:6] != '0) || (araddr[1:0] != 2'h0);
        rd_page_ok <= (page_select <= 3'h1) || (page_select == 3'h7);
      end
      if (rd_pend) begin
        rd_pend <= 1'b0;
        rvalid <= 1'b1;
        rresp <= rd_err ? `SBPR_RESP_SLVERR : `SBPR_RESP_OKAY;
        if (rd_err) begin
          rdata <= '0;
        end else if (rd_idx[3]) begin
          rdata <= {24'h000000, rd_page_ok ? mem_rdata : 8'h00};
        end else begin
          rdata <= {24'h000000, base_rd};
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sbpr_top_sva.sv ----
// assertion checker for the base register bank, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module sbpr_top_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  // phy core side
  input wire logic self_id_done,
  input wire logic [5:0] self_id_node_number,
  input wire logic reg0_status_push,
  input wire logic [7:0] reg0_status_data,
  input wire logic node_number_valid,
  input wire logic [5:0] gap_count,
  input wire logic standby_cmd,
  input wire logic leaf_node,
  input wire logic standby_enter,
  input wire logic bus_reset_drive
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  push_after_done_a: assert property (self_id_done |=> reg0_status_push)
    else $error("no status push after self-id");
  push_data_a: assert property (self_id_done |=>
    reg0_status_data[7:2] == $past(self_id_node_number))
    else $error("status push carries wrong node number");
  push_valid_a: assert property (reg0_status_push |-> node_number_valid)
    else $error("node number not valid at status push");
  read_latency_a: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read answer late");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  read_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  write_latency_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  write_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped before taken");
  gap_reset_a: assert property ($rose(aresetn) |-> gap_count == 6'h3f)
    else $error("gap count not 3f after reset");
  standby_leaf_a: assert property (standby_enter |-> $past(standby_cmd) && $past(leaf_node))
    else $error("standby entered without leaf command");
  // main scenarios reached
  cover property ($rose(bus_reset_drive));
  cover property (reg0_status_push);
  cover property (standby_enter);
endmodule
bind sbpr_top sbpr_top_sva u_sva (.aclk, .aresetn, .arvalid, .arready, .rvalid, .rready,
  .rdata, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .self_id_done,
  .self_id_node_number, .reg0_status_push, .reg0_status_data, .node_number_valid,
  .gap_count, .standby_cmd, .leaf_node, .standby_enter, .bus_reset_drive);
`default_nettype wire

// ---- sbpr_link_model.sv ----
// link controller model that collects the unsolicited status transfers
`timescale 1ns/1ps
`default_nettype none
module sbpr_link_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // status transfer from the register bank
  input wire logic push,
  input wire logic [7:0] data,
  input wire logic node_valid,
  // what the link controller has learned
  output logic [7:0] last_status,
  output int pushes
);
  // node number is trusted only once the status transfer arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pushes <= 0;
      last_status <= 8'h00;
    end else if (push && node_valid) begin
      pushes <= pushes + 1;
      last_status <= data;
    end
  end
endmodule
`default_nettype wire

// ---- sbpr_top_tb.sv ----
// self-checking testbench of the base register bank
`timescale 1ns/1ps
`default_nettype none
module sbpr_top_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, bus_reset_in, self_id_done, tree_id_root, cfg_pkt_gap_load;
  logic cfg_pkt_holdoff_load, cfg_pkt_holdoff, traffic_busy, resume_start, standby_cmd;
  logic config_timeout_event, state_timeout_event, leaf_node, cable_power_ok_pin;
  logic link_power_status_in, reg0_status_push, node_number_valid, bus_reset_drive;
  logic bus_reset_is_short, root_holdoff, standby_enter, self_id_link_active, self_id_contender;
  logic [7:0] awaddr, araddr, reg0_status_data, last_status;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, port_select;
  logic [1:0] bresp, rresp;
  logic [5:0] self_id_node_number, cfg_pkt_gap_count, gap_count;
  logic [2:0] pwr_class_strap, self_id_pwr_class;
  int pushes, fails, tests_run, seed, n, v, se, m[8], pm[64];
  int wm[8] = '{0, 'hff, 0, 'h10, 'hc7, 'hc0, 'hfc, 'hef}; // writable bits per register, leaving out the writable bits 1 and 0 of register 5
  logic [6:0] ev; // one-cycle core events, self_id_done is bit 0
  assign {resume_start, cfg_pkt_holdoff_load, standby_cmd, cfg_pkt_gap_load, bus_reset_in,
    tree_id_root, self_id_done} = ev;
  sbpr_top #(.LONG_CYC(20)) u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .bus_reset_in, .self_id_done, .self_id_node_number,
    .tree_id_root, .cfg_pkt_gap_load, .cfg_pkt_gap_count, .cfg_pkt_holdoff_load,
    .cfg_pkt_holdoff, .traffic_busy, .resume_start, .config_timeout_event,
    .state_timeout_event, .standby_cmd, .leaf_node, .cable_power_ok_pin,
    .link_power_status_in, .pwr_class_strap, .reg0_status_push, .reg0_status_data,
    .node_number_valid, .bus_reset_drive, .bus_reset_is_short, .root_holdoff, .gap_count,
    .standby_enter, .self_id_link_active, .self_id_contender, .self_id_pwr_class,
    .port_select);
  sbpr_link_model u_link (.aclk, .aresetn, .push(reg0_status_push),
    .data(reg0_status_data), .node_valid(node_number_valid), .last_status, .pushes);
  // clock of 40 ns
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one write; address and data offered together, response taken a cycle after it shows
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    logic ta, tw;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ta = 0;
    tw = 0;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || awready;
      tw = tw || wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    chk("bresp", bresp, er);
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  // one read; rready comes late so the answer must stand
  task automatic rd(input logic [7:0] a, e, input logic [1:0] er);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    chk("rdata", rdata, {24'h0, e});
    chk("rresp", rresp, er);
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // register access with the model kept in step
  task automatic wreg(input int k, d);
    wr(8'(k * 4), 8'(d), 2'h0);
    if (k < 8) m[k] = (m[k] & ~wm[k]) | (d & wm[k]);
    else pm[(m[7] >> 5) * 8 + k - 8] = d & 255;
  endtask
  task automatic rreg(input int k);
    int p;
    p = m[7] >> 5;
    if (k < 8) rd(8'(k * 4), 8'(m[k]), 2'h0);
    else if (p > 1 && p < 7) rd(8'(k * 4), 8'h00, 2'h0);
    else rd(8'(k * 4), 8'(pm[p * 8 + k - 8]), 2'h0);
  endtask
  // one-cycle pulse of core event w; the registered standby grant is sampled on the falling edge after the pulse ends
  task automatic pulse(input int w);
    ev <= 7'(1 << w);
    @(posedge aclk);
    ev <= '0;
    @(negedge aclk);
    se = standby_enter;
    @(posedge aclk);
  endtask
  // length of an own bus reset in cycles
  task automatic rlen(input int exp, input logic s);
    int c;
    c = 0;
    while (!bus_reset_drive && c < 99) begin
      @(negedge aclk);
      c++;
    end
    chk("short", bus_reset_is_short, s);
    for (c = 0; bus_reset_drive; c++) @(negedge aclk);
    chk("length", c, exp);
    @(posedge aclk);
  endtask
  // verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #400000;
    fails++;
    conclude();
  end
  initial begin
    seed = 60272;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ev} = '0;
    {cfg_pkt_holdoff, traffic_busy, config_timeout_event} = '0;
    {state_timeout_event, leaf_node, link_power_status_in, awaddr, araddr, wdata} = '0;
    {self_id_node_number, cfg_pkt_gap_count} = '0;
    cable_power_ok_pin = 1'b1;
    wstrb = 4'h1;
    pwr_class_strap = 3'h5;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    m = '{8'h01, 8'h3f, 8'he3, 8'hef, 8'h85, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 8; k++) rreg(k);
    for (int k = 0; k < 8; k++) begin
      if (k != 1 && k != 5) wreg(k, $random(seed));
      rreg(k);
    end
    chk("contender", self_id_contender, (m[4] >> 6) & 1);
    chk("pwr", self_id_pwr_class, m[4] & 7);
    chk("port", port_select, m[7] & 15);
    for (int p = 0; p < 8; p++) begin
      wreg(7, p << 5);
      for (int i = 8; i < 16; i++) wreg(i, $random(seed));
      for (int i = 8; i < 16; i++) rreg(i);
      rreg(1);
    end
    wr(8'h40, 8'hff, 2'h2);
    rd(8'h40, 8'h00, 2'h2);
    n = $random(seed) & 63;
    self_id_node_number <= 6'(n);
    pulse(0);
    pulse(1);
    chk("status", last_status, n * 4 + 1);
    chk("pushes", pushes, 1);
    m[0] = n * 4 + 3;
    rreg(0);
    pulse(2);
    m[0] = n * 4 + 1;
    rreg(0);
    chk("valid", node_number_valid, 0);
    cfg_pkt_holdoff <= 1'b1;
    pulse(5);
    chk("holdoff", root_holdoff, 1);
    wreg(1, 8'h85);
    pulse(2);
    rreg(1);
    pulse(2);
    m[1] = 8'hbf;
    rreg(1);
    v = $random(seed) & 63;
    cfg_pkt_gap_count <= 6'(v);
    pulse(3);
    chk("gap", gap_count, v);
    m[1] = 8'h80 | v;
    traffic_busy <= 1'b1;
    wreg(1, m[1] | 8'h40);
    repeat (5) @(negedge aclk);
    chk("drive", bus_reset_drive, 0);
    @(posedge aclk);
    traffic_busy <= 1'b0;
    rlen(20, 1'b0);
    m[1] = m[1] & 'hbf;
    rreg(1);
    wreg(5, 8'h40);
    rlen(33, 1'b1);
    m[5] = 0;
    m[1] = 8'hbf;
    rreg(1);
    cable_power_ok_pin <= 1'b0;
    link_power_status_in <= 1'b1;
    repeat (4) @(posedge aclk);
    m[0] = n * 4;
    m[5] = 8'h10;
    rreg(0);
    rreg(5);
    chk("link", self_id_link_active, (m[4] >> 7) & 1);
    wreg(5, 8'h80);
    pulse(6);
    m[5] = 8'h94;
    rreg(5);
    pulse(4);
    chk("standby", se, 0);
    leaf_node <= 1'b1;
    wreg(3, 8'h10);
    pulse(4);
    chk("standby", se, 1);
    conclude();
  end
endmodule
`default_nettype wire
